// ---- design/srpo_latched_out.sv ----
// Top of the serial-in, parallel-out shift block with storage register and enabled outputs.
// Assumes clk is the 25 MHz system clock with srst synchronous to it; shift_clock is the
// link clock from the host, unrelated in phase; latch_clock and output_enable_n are pins.
//
// What this block does
// - Eight shift stages take one serial bit per shift and feed an eight-bit storage register.
// - All eight parallel outputs are disabled whenever the active-low output enable is high.
// - Shift stages and storage register run from two independent clocks.
// - Only rising edges of the shift and latch clocks act; falling edges do nothing.
// - A low clear forces every shift stage, and the cascade output, to zero without a clock.
// - Each rising shift edge with clear high moves every stage on and loads the serial input.
// - Each rising latch edge copies all eight shift stages into the storage register.
// - The last stage drives a cascade output that is never disabled, for chaining devices.
// - With both clocks tied, storage captures the stages as they were before the same edge.
`timescale 1ns/10ps
`default_nettype none
`include "srpo_map.svh"

module srpo_latched_out (
    input wire logic clk,
    input wire logic srst,
    input wire logic shift_clock,
    input wire logic shift_clear_n,
    input wire logic serial_data_in,
    input wire logic latch_clock,
    input wire logic output_enable_n,
    output var srpo_pkg::srpo_par_out_t parallel_out,
    output logic serial_data_out
);

    localparam srpo_pkg::srpo_core_t CORE_RST = '{
        oe_s1: `SRPO_OE_N_RST,
        oe_s2: `SRPO_OE_N_RST,
        store: `SRPO_STORE_RST,
        settled: `SRPO_STORE_RST,
        default: '0
    };

    srpo_pkg::srpo_core_t core_reg;
    srpo_pkg::srpo_core_t core_next;
    srpo_pkg::srpo_link_t link_view;
    logic lat_rise;
    logic unsettled;

    // Level pair to rising-edge pulse, after synchronisation
    function automatic logic rose_edge(input logic now_lvl, input logic was_lvl);
        return now_lvl & ~was_lvl;
    endfunction

    // Shift stages live in the link clock domain
    srpo_shift_stage u_shift (
        .shift_clock(shift_clock),
        .shift_clear_n(shift_clear_n),
        .serial_data_in(serial_data_in),
        .link(link_view),
        .serial_data_out(serial_data_out)
    );

    // Latch clock is sampled, so it must stay high and low for two system cycles each
    assign lat_rise = rose_edge(core_reg.lat_s2, core_reg.lat_s3);

    // A word still in flight from the link domain, or just cleared there
    assign unsettled = (core_reg.tog_s2 != core_reg.tog_s3) || (core_reg.word_s2 != core_reg.word_s3);

    always_comb begin
        core_next = core_reg;

        // Two-flop synchroniser for output enable, three flops for latch and toggle; stage one feeds stage two only
        core_next.oe_s1 = output_enable_n;
        core_next.oe_s2 = core_reg.oe_s1;
        core_next.lat_s1 = latch_clock;
        core_next.lat_s2 = core_reg.lat_s1;
        core_next.lat_s3 = core_reg.lat_s2;
        core_next.tog_s1 = link_view.shift_toggle;
        core_next.tog_s2 = core_reg.tog_s1;
        core_next.tog_s3 = core_reg.tog_s2;

        // Stage word crosses bit by bit; incoherent bits are screened by the settle count
        core_next.word_s1 = link_view.stages;
        core_next.word_s2 = core_reg.word_s1;
        core_next.word_s3 = core_reg.word_s2;

        // Settle count: the crossed word is trusted only after it stops moving
        if (unsettled) begin
            core_next.quiet_cnt = '0;
        end else if (core_reg.quiet_cnt != `SRPO_SETTLE_CYCLES) begin
            core_next.quiet_cnt = core_reg.quiet_cnt + `SRPO_SETTLE_STEP;
        end

        // Settled copy lags a shift, so a latch edge that arrives with that shift
        // still sees the stages from before it, as with tied clocks
        if (!unsettled && (core_reg.quiet_cnt == `SRPO_SETTLE_CYCLES)) begin
            core_next.settled = core_reg.word_s3;
        end

        // Storage moves only on a latch rising edge; clear and shifting leave it alone
        if (lat_rise) begin
            core_next.store = core_reg.settled;
        end

        // Output pins from flip-flops; stage zero lands on output bit zero
        core_next.pins.data = core_reg.store;
        core_next.pins.en = ~core_reg.oe_s2;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            core_reg <= CORE_RST;
        end else begin
            core_reg <= core_next;
        end
    end

    assign parallel_out = core_reg.pins;

    default clocking main_cb @(posedge clk);
    endclocking

    default disable iff (srst);

    sequence latch_rise_s;
        core_reg.lat_s2 && !core_reg.lat_s3;
    endsequence

    sequence latch_fall_s;
        !core_reg.lat_s2 && core_reg.lat_s3;
    endsequence

    sequence shift_arrive_s;
        core_reg.tog_s2 != core_reg.tog_s3;
    endsequence

    sequence word_move_s;
        core_reg.word_s2 != core_reg.word_s3;
    endsequence

    sequence pin_rise_s;
        !latch_clock ##1 latch_clock [*3];
    endsequence

    property store_steady_p;
        !lat_rise |=> $stable(core_reg.store);
    endproperty

    oe_off_a: assert property (
        output_enable_n [*3] |=> !parallel_out.en)
        else $error("outputs enabled while output enable is high");

    oe_on_a: assert property (
        !output_enable_n [*3] |=> parallel_out.en)
        else $error("outputs disabled while output enable is low");

    oe_follow_a: assert property (
        $rose(output_enable_n) ##1 output_enable_n ##1 output_enable_n |=> !parallel_out.en)
        else $error("output disable did not take effect within three cycles");

    latch_copy_a: assert property (
        latch_rise_s |=> core_reg.store == $past(core_reg.settled))
        else $error("latch edge did not copy the settled stages");

    latch_hold_a: assert property (
        store_steady_p)
        else $error("storage changed without a latch edge");

    fall_ignored_a: assert property (
        latch_fall_s |=> $stable(core_reg.store))
        else $error("falling latch edge changed storage");

    pin_to_store_a: assert property (
        pin_rise_s |-> ##1 core_reg.store == $past(core_reg.settled))
        else $error("latch pin edge not taken three cycles later");

    pins_follow_a: assert property (
        latch_rise_s |-> ##2 parallel_out.data == $past(core_reg.settled, 2))
        else $error("parallel outputs do not show latched stages");

    settle_wait_a: assert property (
        (shift_arrive_s or word_move_s) |=> $stable(core_reg.settled) [*3])
        else $error("settled copy took a word still in flight");

    tied_edge_a: assert property (
        (latch_rise_s and shift_arrive_s) |=> core_reg.store == $past(core_reg.settled)
            ##1 core_reg.store != core_reg.word_s3 || core_reg.store == $past(core_reg.store))
        else $error("tied-clock latch took the post-shift stages");

    settle_take_a: assert property (
        !unsettled [*4] |=> core_reg.settled == $past(core_reg.word_s3))
        else $error("settled copy missed a quiet eight-bit word");

endmodule
`default_nettype wire

// ---- design/srpo_map.svh ----
// Constants for the serial-in, parallel-out latched shift block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SRPO_MAP_SVH
`define SRPO_MAP_SVH

// Stage count of the shift register and of the storage register
`define SRPO_WIDTH 8
// Stage positions: first stage takes the serial input, last feeds the cascade output
`define SRPO_FIRST_STAGE 0
`define SRPO_LAST_STAGE 7
// Reset values
`define SRPO_STAGE_RST 8'h00
`define SRPO_STORE_RST 8'h00
`define SRPO_OE_N_RST 1'b1
`define SRPO_TOGGLE_RST 1'b0
// System clock cycles a crossed shift word must stay unchanged before it counts as settled
`define SRPO_SETTLE_CYCLES 2'h2
`define SRPO_SETTLE_STEP 2'h1

`endif

// ---- design/srpo_pkg.sv ----
// Types for the serial-in, parallel-out latched shift block.
// Assumes srpo_map.svh is on the include path.
`include "srpo_map.svh"

package srpo_pkg;

    typedef logic [`SRPO_WIDTH-1:0] srpo_word_t;

    // Link-domain state, also what crosses to the system clock domain
    typedef struct packed {
        srpo_word_t stages;
        logic shift_toggle;
    } srpo_link_t;

    // Parallel output group: data and its output enable
    typedef struct packed {
        srpo_word_t data;
        logic en;
    } srpo_par_out_t;

    // All system-clock state of the top module
    typedef struct packed {
        logic oe_s1;
        logic oe_s2;
        logic lat_s1;
        logic lat_s2;
        logic lat_s3;
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        srpo_word_t word_s1;
        srpo_word_t word_s2;
        srpo_word_t word_s3;
        logic [1:0] quiet_cnt;
        srpo_word_t settled;
        srpo_word_t store;
        srpo_par_out_t pins;
    } srpo_core_t;

endpackage

// ---- design/srpo_shift_stage.sv ----
// Shift register stages, clocked by the link's shift clock.
// Assumes the host clears the stages once before the first shift; the clock may stand still.
`timescale 1ns/10ps
`default_nettype none
`include "srpo_map.svh"

module srpo_shift_stage (
    input wire logic shift_clock,
    input wire logic shift_clear_n,
    input wire logic serial_data_in,
    output var srpo_pkg::srpo_link_t link,
    output logic serial_data_out
);

    srpo_pkg::srpo_link_t link_reg;
    srpo_pkg::srpo_link_t link_next;

    always_comb begin
        link_next = link_reg;
        for (int i = `SRPO_FIRST_STAGE + 1; i <= `SRPO_LAST_STAGE; i++) begin
            link_next.stages[i] = link_reg.stages[i-1];
        end
        link_next.stages[`SRPO_FIRST_STAGE] = serial_data_in;
        // Toggle marks each shift so the far domain can tell a settled word
        link_next.shift_toggle = ~link_reg.shift_toggle;
    end

    // Rising edge only; clear overrides at once, even with the clock stopped
    always_ff @(posedge shift_clock or negedge shift_clear_n) begin
        if (!shift_clear_n) begin
            link_reg <= '{stages: `SRPO_STAGE_RST, shift_toggle: `SRPO_TOGGLE_RST};
        end else begin
            link_reg <= link_next;
        end
    end

    assign link = link_reg;
    assign serial_data_out = link_reg.stages[`SRPO_LAST_STAGE];

    shift_move_a: assert property (
        @(posedge shift_clock) disable iff (!shift_clear_n)
        1'b1 |=> link_reg.stages == {$past(link_reg.stages[`SRPO_LAST_STAGE-1:0]), $past(serial_data_in)})
        else $error("shift stages did not advance by one");

    cascade_delay_a: assert property (
        @(posedge shift_clock) disable iff (!shift_clear_n)
        shift_clear_n [*8] |=> serial_data_out == $past(serial_data_in, 8))
        else $error("cascade output is not the serial input eight shifts late");

    clear_zero_a: assert property (
        @(posedge shift_clock)
        !shift_clear_n |-> (link_reg.stages == `SRPO_STAGE_RST) && !serial_data_out)
        else $error("stages not zero while clear is low");

endmodule
`default_nettype wire

// ---- dv/srpo_host_model.sv ----
// Host model: drives serial data, link clock, clear, latch and enable pins.
// Assumes the bench calls one task at a time and supplies the system clock.
`timescale 1ns/10ps
`default_nettype none
module srpo_host_model (
    input wire logic clk,
    output logic shift_clock,
    output logic shift_clear_n,
    output logic serial_data_in,
    output logic latch_clock,
    output logic output_enable_n
);
    initial begin
        shift_clock = 1'b0;
        shift_clear_n = 1'b0;
        serial_data_in = 1'b0;
        latch_clock = 1'b0;
        output_enable_n = 1'b1;
    end
    // Link clock runs only inside a frame; data flips after it so stale bits never pass
    task automatic shift_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            serial_data_in = w[i];
            #32 shift_clock = 1'b1;
            #32 shift_clock = 1'b0;
        end
        serial_data_in = ~w[0];
    endtask
    task automatic set_pins(input logic clr_n, input logic oe_n);
        @(negedge clk);
        shift_clear_n = clr_n;
        output_enable_n = oe_n;
    endtask
    task automatic latch_level(input logic v);
        repeat (8) @(negedge clk);
        latch_clock = v;
        repeat (3) @(negedge clk);
    endtask
    // Both clocks rise together, as when the host ties them
    task automatic tied_edge(input logic b);
        repeat (8) @(negedge clk);
        serial_data_in = b;
        @(negedge clk);
        shift_clock = 1'b1;
        latch_clock = 1'b1;
        #32 shift_clock = 1'b0;
        serial_data_in = ~b;
        repeat (3) @(negedge clk);
        latch_clock = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/srpo_latched_out_bench.sv ----
// Bench for the latched shift block: scenarios run through the host model.
// Assumes the design files and package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module srpo_latched_out_bench;
    logic clk, srst, shift_clock, shift_clear_n, serial_data_in, latch_clock, output_enable_n, serial_data_out;
    srpo_pkg::srpo_par_out_t parallel_out;
    srpo_pkg::srpo_word_t pins;
    int error_cnt = 0;
    int samples_checked = 0;
    // Outputs float when disabled
    assign pins = parallel_out.en ? parallel_out.data : 8'hzz;
    srpo_host_model srpo_host_model_inst (.clk(clk), .shift_clock(shift_clock), .shift_clear_n(shift_clear_n),
        .serial_data_in(serial_data_in), .latch_clock(latch_clock), .output_enable_n(output_enable_n));
    srpo_latched_out srpo_latched_out_inst (.clk(clk), .srst(srst), .shift_clock(shift_clock),
        .shift_clear_n(shift_clear_n), .serial_data_in(serial_data_in), .latch_clock(latch_clock),
        .output_enable_n(output_enable_n), .parallel_out(parallel_out), .serial_data_out(serial_data_out));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic complete_run();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check_word(input srpo_pkg::srpo_word_t got, input srpo_pkg::srpo_word_t exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %b", $time, m, got);
        end
    endtask
    // Bounded wait for the storage word; a miss ends the run
    task automatic wait_data(input srpo_pkg::srpo_word_t exp);
        int n;
        n = 0;
        while (parallel_out.data !== exp && n < 16) begin
            @(negedge clk);
            n++;
        end
        check_word(parallel_out.data, exp, "storage");
        if (n >= 16) complete_run();
    endtask
    task automatic t_reset();
        check_word(pins, 8'hzz, "pins after reset");
        check_word(parallel_out.data, 8'h00, "data after reset");
        check_bit(serial_data_out, 1'b0, "cascade in clear");
        srpo_host_model_inst.set_pins(1'b1, 1'b0);
    endtask
    task automatic t_shift_latch();
        srpo_host_model_inst.shift_word(8'ha5);
        check_bit(serial_data_out, 1'b1, "cascade");
        srpo_host_model_inst.latch_level(1'b1);
        srpo_host_model_inst.latch_level(1'b0);
        wait_data(8'ha5);
        check_word(pins, 8'ha5, "pins");
        check_bit(pins[0], 1'b1, "bit zero");
    endtask
    task automatic t_hold_clear();
        // Last stage ends high, so the clear below has something to pull down
        srpo_host_model_inst.shift_word(8'hc3);
        check_bit(serial_data_out, 1'b1, "cascade c3");
        repeat (10) @(negedge clk);
        check_word(pins, 8'ha5, "held");
        srpo_host_model_inst.set_pins(1'b0, 1'b0);
        #1 check_bit(serial_data_out, 1'b0, "clear");
        srpo_host_model_inst.shift_word(8'hff);
        check_bit(serial_data_out, 1'b0, "shift in clear");
        check_word(pins, 8'ha5, "held in clear");
        srpo_host_model_inst.set_pins(1'b1, 1'b0);
        srpo_host_model_inst.latch_level(1'b1);
        srpo_host_model_inst.latch_level(1'b0);
        wait_data(8'h00);
    endtask
    task automatic t_disable();
        srpo_host_model_inst.set_pins(1'b1, 1'b1);
        repeat (5) @(negedge clk);
        check_word(pins, 8'hzz, "disabled");
        srpo_host_model_inst.shift_word(8'h81);
        check_bit(serial_data_out, 1'b1, "cascade disabled");
        srpo_host_model_inst.latch_level(1'b1);
        wait_data(8'h81);
        check_word(pins, 8'hzz, "still disabled");
        srpo_host_model_inst.shift_word(8'h5a);
        srpo_host_model_inst.latch_level(1'b0);
        repeat (8) @(negedge clk);
        check_word(parallel_out.data, 8'h81, "falling latch");
        srpo_host_model_inst.set_pins(1'b1, 1'b0);
        repeat (5) @(negedge clk);
        check_word(pins, 8'h81, "enabled");
    endtask
    task automatic t_tied();
        srpo_host_model_inst.tied_edge(1'b1);
        wait_data(8'h5a);
        repeat (8) @(negedge clk);
        check_word(pins, 8'h5a, "one behind");
        srpo_host_model_inst.latch_level(1'b1);
        srpo_host_model_inst.latch_level(1'b0);
        wait_data(8'hb5);
    endtask
    initial begin
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_shift_latch();
        t_hold_clear();
        t_disable();
        t_tied();
        complete_run();
    end
    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
